// ### design/tsi_connection_word_decode.sv
// connection memory and per-timeslot decode of the connection words
//
// What this block does
// [RQ1] gain bits 7-3; 11111 mutes channel
// [RQ2] high bit 2 set: send low word
// [RQ3] high bit 2 clear: low word addresses memory
// [RQ4] high bit 1 picks minimum or constant delay
// [RQ5] bit 0 gates driver when pin high, ctl5 clear
// [RQ6] conference locations: attenuation and noise suppression
// [RQ7] noise code selects none, 9, 16, 32 units
// [RQ8] low bits 7-5 are the source block
// [RQ9] low bits 4-0 are the source channel
// [RQ10] block 010 addresses tone generator channels
// [RQ11] block 011: conferences 00-0e, d-channel at 10
// [RQ12] blocks 100-111 address expansion blocks 1-4
// [RQ13] locations 60-6e name conference party channels
// [RQ14] location 6f selects d-channel receive channel
// [RQ15] locations 70, 71 feed energy detectors a, b
// [RQ16] every timeslot reads words and applies them
`timescale 1ns/1ps
`include "tsi_consts.svh"

module tsi_connection_word_decode (
    // clock and reset
    input  wire logic               CLOCK_I,
    input  wire logic               RESET_I,
    // connection memory port
    input  wire logic [6:0]         CM_ADDR_I,
    input  wire logic               CM_HIGH_SEL_I,
    input  wire logic               CM_WR_I,
    input  wire logic               CM_RD_I,
    input  wire logic [7:0]         CM_WDATA_I,
    output logic [7:0]              CM_RDATA_O,
    output logic                    CM_RVALID_O,
    // frame scheduler
    input  wire logic               FRAME_START_I,
    input  wire logic               SLOT_TICK_I,
    // drive control
    input  wire logic               OUTPUT_DRIVE_ENABLE_PIN_I,
    input  wire logic               CTL_BIT5_I,
    // data memory read
    output logic [7:0]              DM_ADDR_O,
    output logic                    DM_RD_O,
    input  wire logic [7:0]         DM_DATA_I,
    // outgoing channel result
    output tsi_pkg::chan_out_t      CHAN_OUT_O,
    output logic                    CHAN_VALID_O,
    // conference party result
    output tsi_pkg::party_cfg_t     PARTY_OUT_O,
    output logic                    PARTY_VALID_O,
    // incoming channel selections
    output logic [7:0]              DCH_RX_SEL_O,
    output logic [7:0]              ENERGY_A_SEL_O,
    output logic [7:0]              ENERGY_B_SEL_O
);

    // connection memory, high and low word per location
    logic [7:0]                 connect_word_high [`CM_DEPTH];
    logic [7:0]                 connect_word_low  [`CM_DEPTH];

    // scheduler state
    // one slot latched per tick, results three cycles on
    logic [6:0]                 slot_loc;      // location served next
    logic [6:0]                 next_slot_loc; // following location
    logic                       stage_valid;   // words latched, awaiting data
    logic [6:0]                 stage_loc;     // location of latched words
    logic [7:0]                 stage_high;    // latched high word
    logic [7:0]                 stage_low;     // latched low word

    // decode of the latched words
    // combinational, meaningful while stage_valid is high
    logic                       stage_is_conf; // conference party location
    logic                       stage_is_out;  // outgoing channel location
    logic                       stage_msg;     // message mode
    logic [2:0]                 stage_block;   // source block
    logic [4:0]                 stage_chan;    // source channel
    logic [4:0]                 stage_gain;    // gain or attenuation code
    tsi_pkg::src_class_t        stage_class;   // source class
    logic                       stage_drive;   // driver enable

    // memory writes, one location per cycle
    // every entry has its own write process, so each
    // word keeps a single driver and reset clears it
    generate
        for (genvar loc = 0; loc < `CM_DEPTH; loc++) begin : g_cm
            always_ff @(posedge CLOCK_I) begin
                if (RESET_I) begin
                    connect_word_high[loc] <= `CM_WORD_RESET;
                    connect_word_low[loc]  <= `CM_WORD_RESET;
                end else if (CM_WR_I && CM_ADDR_I == 7'(loc)) begin
                    // host selects which half is written
                    if (CM_HIGH_SEL_I) begin
                        connect_word_high[loc] <= CM_WDATA_I;
                    end else begin
                        connect_word_low[loc] <= CM_WDATA_I;
                    end
                end
            end
        end
    endgenerate

    // memory read back, one cycle after the strobe
    // read data holds until the next read strobe
    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            CM_RDATA_O  <= 8'h00;
            CM_RVALID_O <= 1'b0;
        end else begin
            CM_RVALID_O <= CM_RD_I;
            if (CM_RD_I) begin
                CM_RDATA_O <= CM_HIGH_SEL_I ? connect_word_high[CM_ADDR_I] : connect_word_low[CM_ADDR_I];
            end
        end
    end

    // location stepping wraps after the last special location
    // locations 0x72..0x7f store words for the host
    // but are never reached by the scan
    always_comb begin
        if (slot_loc == `CM_LAST_LOC) begin
            next_slot_loc = 7'h00;
        end else begin
            next_slot_loc = slot_loc + 7'h01;
        end
    end

    // frame-synchronous slot counter
    // frame start wins over a tick in the same cycle
    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            slot_loc <= 7'h00;
        end else if (FRAME_START_I) begin
            slot_loc <= 7'h00;
        end else if (SLOT_TICK_I) begin
            slot_loc <= next_slot_loc; // RQ16
        end
    end

    // latch the words of the slot being served
    // a tick that meets frame start is dropped
    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            stage_valid <= 1'b0;
            stage_loc   <= 7'h00;
            stage_high  <= 8'h00;
            stage_low   <= 8'h00;
        end else begin
            stage_valid <= SLOT_TICK_I && !FRAME_START_I;
            if (SLOT_TICK_I && !FRAME_START_I) begin
                stage_loc  <= slot_loc;
                stage_high <= connect_word_high[slot_loc]; // RQ16
                stage_low  <= connect_word_low[slot_loc];
            end
        end
    end

    // field decode of the latched words
    // conference locations reuse the gain and low bits
    always_comb begin
        stage_is_conf = stage_loc >= `LOC_CONF_FIRST && stage_loc <= `LOC_CONF_LAST; // RQ13
        stage_is_out  = stage_loc < `LOC_CONF_FIRST;
        stage_msg     = stage_high[`HI_MSG_BIT];
        stage_gain    = stage_high[`HI_GAIN_MSB:`HI_GAIN_LSB]; // RQ1 RQ6
        stage_block   = stage_low[`LO_BLOCK_MSB:`LO_BLOCK_LSB]; // RQ8
        stage_chan    = stage_low[`LO_CHAN_MSB:`LO_CHAN_LSB]; // RQ9
        // driver gated by pin and control bit 5
        // pin high with bit 5 set forces the driver on
        // pin low always leaves the slot undriven
        if (OUTPUT_DRIVE_ENABLE_PIN_I && !CTL_BIT5_I) begin
            stage_drive = stage_high[`HI_DRIVE_BIT]; // RQ5
        end else if (OUTPUT_DRIVE_ENABLE_PIN_I) begin
            stage_drive = 1'b1;
        end else begin
            stage_drive = 1'b0;
        end
    end

    // source class from block and channel
    // message mode overrides any block decode
    always_comb begin
        if (stage_msg) begin
            stage_class = tsi_pkg::SRC_MESSAGE; // RQ2
        end else if (stage_block == `BLK_LOCAL_A || stage_block == `BLK_LOCAL_B) begin
            stage_class = tsi_pkg::SRC_LOCAL; // RQ8
        end else if (stage_block == `BLK_TONE) begin
            stage_class = tsi_pkg::SRC_TONE; // RQ10
        end else if (stage_block == `BLK_SPECIAL) begin
            // conference outputs, d-channel transmit, rest unused
            if (stage_chan <= `CH_CONF_LAST) begin
                stage_class = tsi_pkg::SRC_CONFERENCE; // RQ11
            end else if (stage_chan == `CH_DCH_TX) begin
                stage_class = tsi_pkg::SRC_DCHANNEL_TX; // RQ11
            end else begin
                stage_class = tsi_pkg::SRC_UNUSED;
            end
        end else begin
            stage_class = tsi_pkg::SRC_EXPANSION; // RQ12
        end
    end

    // data memory request for switched outgoing slots
    // message and conference slots never fetch
    // the address is the whole low word
    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            DM_ADDR_O <= 8'h00;
            DM_RD_O   <= 1'b0;
        end else begin
            DM_RD_O <= stage_valid && stage_is_out && !stage_msg; // RQ3
            if (stage_valid) begin
                DM_ADDR_O <= stage_low; // RQ3
            end
        end
    end

    // second stage holds decode while data memory answers
    // the byte must arrive in the same cycle as the request
    tsi_pkg::chan_out_t         pend_chan;   // decoded channel awaiting byte
    logic                       pend_valid;  // outgoing slot in flight

    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            pend_chan  <= '0;
            pend_valid <= 1'b0;
        end else begin
            pend_valid <= stage_valid && stage_is_out;
            if (stage_valid && stage_is_out) begin
                pend_chan.loc               <= stage_loc;
                pend_chan.data              <= stage_low; // RQ2
                pend_chan.gain_code         <= stage_gain; // RQ1
                pend_chan.mute              <= stage_gain == `GAIN_MUTE_CODE; // RQ1
                pend_chan.delay_mode_select <= stage_high[`HI_DELAY_BIT]; // RQ4
                pend_chan.drive             <= stage_drive; // RQ5
                pend_chan.src_class         <= stage_class;
                pend_chan.src_block         <= stage_block;
                pend_chan.src_chan          <= stage_chan;
            end
        end
    end

    // final outgoing channel result
    // gain is passed on as a code; only full mute
    // changes the byte here
    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            CHAN_OUT_O   <= '0;
            CHAN_VALID_O <= 1'b0;
        end else begin
            CHAN_VALID_O <= pend_valid;
            if (pend_valid) begin
                CHAN_OUT_O <= pend_chan;
                // muted channel sends silence, else message or switched byte
                if (pend_chan.mute) begin
                    CHAN_OUT_O.data <= `SILENCE_BYTE; // RQ1
                end else if (pend_chan.src_class != tsi_pkg::SRC_MESSAGE) begin
                    CHAN_OUT_O.data <= DM_DATA_I; // RQ3
                end
            end
        end
    end

    // conference party settings, aligned with the channel result
    // bit 2 is not used at these locations
    // party index is the location less the first party
    tsi_pkg::party_cfg_t        pend_party;  // party awaiting output
    logic                       pend_pvalid; // party slot in flight

    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            pend_party    <= '0;
            pend_pvalid   <= 1'b0;
            PARTY_OUT_O   <= '0;
            PARTY_VALID_O <= 1'b0;
        end else begin
            pend_pvalid   <= stage_valid && stage_is_conf;
            PARTY_VALID_O <= pend_pvalid;
            if (stage_valid && stage_is_conf) begin
                pend_party.party    <= 4'(stage_loc - `LOC_CONF_FIRST);
                pend_party.atten    <= stage_gain; // RQ6
                pend_party.noise_suppress_level <=
                    tsi_pkg::ns_level_t'(stage_high[`HI_NS_MSB:`HI_NS_LSB]); // RQ6 RQ7
                pend_party.incoming <= stage_low; // RQ13
            end
            if (pend_pvalid) begin
                PARTY_OUT_O <= pend_party;
            end
        end
    end

    // incoming channel selections follow the memory directly
    // these locations never pulse a result; their
    // low words are copied out every cycle
    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            DCH_RX_SEL_O   <= 8'h00;
            ENERGY_A_SEL_O <= 8'h00;
            ENERGY_B_SEL_O <= 8'h00;
        end else begin
            DCH_RX_SEL_O   <= connect_word_low[`LOC_DCH_RX_SEL]; // RQ14
            ENERGY_A_SEL_O <= connect_word_low[`LOC_ENERGY_A_SEL]; // RQ15
            ENERGY_B_SEL_O <= connect_word_low[`LOC_ENERGY_B_SEL]; // RQ15
        end
    end

endmodule : tsi_connection_word_decode

// ### design/tsi_consts.svh
// constants for the connection word decoder: locations, field positions, codes
`ifndef TSI_CONSTS_SVH
`define TSI_CONSTS_SVH

// connection memory geometry
`define CM_ADDR_W          7
`define CM_DEPTH           128
`define CM_LAST_LOC        7'h71
`define CM_WORD_RESET      8'h00

// special locations
`define LOC_CONF_FIRST     7'h60
`define LOC_CONF_LAST      7'h6e
`define LOC_DCH_RX_SEL     7'h6f
`define LOC_ENERGY_A_SEL   7'h70
`define LOC_ENERGY_B_SEL   7'h71

// high word fields
`define HI_GAIN_MSB        7
`define HI_GAIN_LSB        3
`define HI_MSG_BIT         2
`define HI_DELAY_BIT       1
`define HI_DRIVE_BIT       0
`define HI_NS_MSB          1
`define HI_NS_LSB          0
`define GAIN_MUTE_CODE     5'h1f

// low word fields
`define LO_BLOCK_MSB       7
`define LO_BLOCK_LSB       5
`define LO_CHAN_MSB        4
`define LO_CHAN_LSB        0

// source blocks
`define BLK_LOCAL_A        3'h0
`define BLK_LOCAL_B        3'h1
`define BLK_TONE           3'h2
`define BLK_SPECIAL        3'h3
`define CH_CONF_LAST       5'h0e
`define CH_DCH_TX          5'h10

// byte sent on a muted channel
`define SILENCE_BYTE       8'hff

`endif

// ### design/tsi_pkg.sv
// types shared by the connection word decoder
package tsi_pkg;

    // where an outgoing channel takes its byte from
    typedef enum logic [2:0] {
        SRC_LOCAL,
        SRC_TONE,
        SRC_CONFERENCE,
        SRC_DCHANNEL_TX,
        SRC_EXPANSION,
        SRC_UNUSED,
        SRC_MESSAGE
    } src_class_t;

    // noise suppression thresholds, in 1/4096 (a-law) or 1/8159 (u-law)
    typedef enum logic [1:0] {
        NS_NONE,
        NS_UNITS_9,
        NS_UNITS_16,
        NS_UNITS_32
    } ns_level_t;

    // one outgoing channel as handed to the datapath
    typedef struct packed {
        logic [6:0] loc;
        logic [7:0] data;
        logic [4:0] gain_code;
        logic       mute;
        logic       delay_mode_select;
        logic       drive;
        src_class_t src_class;
        logic [2:0] src_block;
        logic [4:0] src_chan;
    } chan_out_t;

    // one conference party setting
    typedef struct packed {
        logic [3:0] party;
        logic [4:0] atten;
        ns_level_t  noise_suppress_level;
        logic [7:0] incoming;
    } party_cfg_t;

endpackage : tsi_pkg

// ### tb/test_tsi_connection_word_decode.sv
// self-checking bench for the connection word decoder
`timescale 1ns/1ps
module test_tsi_connection_word_decode;
    logic clk, rst, cm_hi, cm_wr, cm_rd, fs, tick, pin, c5, cm_rvalid, dm_rd, chan_valid, party_valid;
    logic [6:0] cm_addr;
    logic [7:0] cm_wdata, cm_rdata, dm_addr, dm_data, dch_sel, ea_sel, eb_sel;
    tsi_pkg::chan_out_t  chan_out, got_c, exp_c;
    tsi_pkg::party_cfg_t party_out, got_p, exp_p;
    int num_errors, checked;
    // data memory stand-in: byte is a fixed scramble of its address
    assign dm_data = dm_addr ^ 8'h5a;
    tsi_connection_word_decode i_dut (.CLOCK_I(clk), .RESET_I(rst), .CM_ADDR_I(cm_addr), .CM_HIGH_SEL_I(cm_hi),
        .CM_WR_I(cm_wr), .CM_RD_I(cm_rd), .CM_WDATA_I(cm_wdata), .CM_RDATA_O(cm_rdata), .CM_RVALID_O(cm_rvalid),
        .FRAME_START_I(fs), .SLOT_TICK_I(tick), .OUTPUT_DRIVE_ENABLE_PIN_I(pin), .CTL_BIT5_I(c5),
        .DM_ADDR_O(dm_addr), .DM_RD_O(dm_rd), .DM_DATA_I(dm_data), .CHAN_OUT_O(chan_out),
        .CHAN_VALID_O(chan_valid), .PARTY_OUT_O(party_out), .PARTY_VALID_O(party_valid),
        .DCH_RX_SEL_O(dch_sel), .ENERGY_A_SEL_O(ea_sel), .ENERGY_B_SEL_O(eb_sel));
    // 25 ns clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // next edge, then step off it
    task automatic tock();
        @(posedge clk);
        #2;
    endtask : tock
    // compare and count
    task automatic check(input logic [39:0] seen, input logic [39:0] want);
        checked++;
        if (seen !== want) begin
            num_errors++;
            $display("[ERR] %0t seen %h want %h", $time, seen, want);
        end
    endtask : check
    // verdict and end of run
    task automatic give_verdict();
        if (num_errors == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : give_verdict
    // one write strobe plus an idle cycle
    task automatic cm_write(input logic [6:0] a, input logic h, input logic [7:0] d);
        cm_addr = a;
        cm_hi = h;
        cm_wdata = d;
        cm_wr = 1'b1;
        tock();
        cm_wr = 1'b0;
        tock();
    endtask : cm_write
    // one read, answer one cycle after the strobe
    task automatic cm_read(input logic [6:0] a, input logic h, input logic [7:0] want);
        cm_addr = a;
        cm_hi = h;
        cm_rd = 1'b1;
        tock();
        cm_rd = 1'b0;
        check(40'(cm_rvalid), 40'h1);
        check(40'(cm_rdata), 40'(want));
        tock();
    endtask : cm_read
    // scan a frame up to loc with back-to-back ticks, capture its result
    // the tick that meets frame start must be dropped by the design
    task automatic run_slot(input logic [6:0] loc);
        int n;
        fs = 1'b1;
        tick = 1'b1;
        tock();
        fs = 1'b0;
        repeat (loc + 1) tock();
        tick = 1'b0;
        for (n = 0; n < 8; n++) begin
            if (chan_valid === 1'b1 && chan_out.loc === loc) break;
            if (loc >= 7'h60 && party_valid === 1'b1 && party_out.party === 4'(loc - 7'h60)) break;
            tock();
        end
        got_c = chan_out;
        got_p = party_out;
        if (n == 8) begin
            num_errors++;
            give_verdict();
        end
    endtask : run_slot
    // outgoing channel: program both words, scan, compare whole result
    task automatic chan_case(input logic [6:0] loc, input logic [7:0] hi, input logic [7:0] lo, input logic p,
                             input logic f);
        pin = p;
        c5 = f;
        cm_write(loc, 1'b1, hi);
        cm_write(loc, 1'b0, lo);
        run_slot(loc);
        exp_c.loc = loc;
        exp_c.gain_code = hi[7:3];
        exp_c.mute = (hi[7:3] == 5'h1f);
        exp_c.data = exp_c.mute ? 8'hff : hi[2] ? lo : lo ^ 8'h5a;
        exp_c.delay_mode_select = hi[1];
        exp_c.drive = p & (f | hi[0]);
        exp_c.src_block = lo[7:5];
        exp_c.src_chan = lo[4:0];
        if (hi[2]) exp_c.src_class = tsi_pkg::SRC_MESSAGE;
        else if (lo[7:5] < 3'h2) exp_c.src_class = tsi_pkg::SRC_LOCAL;
        else if (lo[7:5] == 3'h2) exp_c.src_class = tsi_pkg::SRC_TONE;
        else if (lo[7]) exp_c.src_class = tsi_pkg::SRC_EXPANSION;
        else if (lo[4:0] <= 5'h0e) exp_c.src_class = tsi_pkg::SRC_CONFERENCE;
        else if (lo[4:0] == 5'h10) exp_c.src_class = tsi_pkg::SRC_DCHANNEL_TX;
        else exp_c.src_class = tsi_pkg::SRC_UNUSED;
        check(40'(got_c), 40'(exp_c));
    endtask : chan_case
    // conference party: attenuation, suppression, incoming channel
    task automatic party_case(input logic [6:0] loc, input logic [7:0] hi, input logic [7:0] lo);
        cm_write(loc, 1'b1, hi);
        cm_write(loc, 1'b0, lo);
        run_slot(loc);
        exp_p.party = 4'(loc - 7'h60);
        exp_p.atten = hi[7:3];
        exp_p.noise_suppress_level = tsi_pkg::ns_level_t'(hi[1:0]);
        exp_p.incoming = lo;
        check(40'(got_p), 40'(exp_p));
    endtask : party_case
    // main sequence
    initial begin
        {rst, cm_hi, cm_wr, cm_rd, fs, tick, pin, c5, cm_addr, cm_wdata} = '0;
        rst = 1'b1;
        num_errors = 0;
        checked = 0;
        repeat (5) @(posedge clk);
        #2 rst = 1'b0;
        cm_read(7'h30, 1'b1, 8'h00);
        for (int b = 0; b < 8; b++)
            chan_case(7'(b), {5'(b * 3), 1'b0, 1'(b), 1'b1}, {3'(b), 5'h13}, 1'b1, 1'b0);
        for (int c = 13; c < 18; c++)
            chan_case(7'h20, 8'h11, {3'h3, 5'(c)}, 1'b1, 1'b0);
        chan_case(7'h21, 8'hf9, 8'h21, 1'b1, 1'b0);
        chan_case(7'h5f, 8'h05, 8'ha5, 1'b1, 1'b0);
        for (int k = 0; k < 8; k++)
            chan_case(7'h10, {7'h29, 1'(k >> 2)}, 8'h44, 1'(k), 1'(k >> 1));
        for (int n = 0; n < 4; n++)
            party_case(7'h6e - 7'(n * 4), {5'(n + 4), 1'b1, 2'(n)}, 8'(n + 64));
        cm_write(7'h6f, 1'b0, 8'h9c);
        cm_write(7'h70, 1'b0, 8'h3a);
        cm_write(7'h71, 1'b0, 8'he1);
        cm_write(7'h6f, 1'b1, 8'h00);
        check(40'(dch_sel), 40'h9c);
        check(40'(ea_sel), 40'h3a);
        check(40'(eb_sel), 40'he1);
        cm_write(7'h7f, 1'b1, 8'h6b);
        cm_read(7'h7f, 1'b1, 8'h6b);
        cm_read(7'h5f, 1'b0, 8'ha5);
        give_verdict();
    end
endmodule : test_tsi_connection_word_decode

// ### tb/tsi_decode_assertions.sv
// concurrent checks on the connection word decoder ports
`timescale 1ns/1ps
module tsi_decode_checker (
    // clock and reset
    input wire logic                CLOCK_I,
    input wire logic                RESET_I,
    // scheduler and drive control
    input wire logic                FRAME_START_I,
    input wire logic                SLOT_TICK_I,
    input wire logic                OUTPUT_DRIVE_ENABLE_PIN_I,
    input wire logic                CTL_BIT5_I,
    // data memory and results
    input wire logic                DM_RD_O,
    input wire logic [7:0]          DM_DATA_I,
    input wire tsi_pkg::chan_out_t  CHAN_OUT_O,
    input wire logic                CHAN_VALID_O,
    input wire tsi_pkg::party_cfg_t PARTY_OUT_O,
    input wire logic                PARTY_VALID_O
);
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (RESET_I);
    // fetched byte appears one cycle after the read request
    sequence dm_fetch;
        ##1 CHAN_VALID_O && (CHAN_OUT_O.mute || CHAN_OUT_O.data == $past(DM_DATA_I));
    endsequence
    chk_mute_byte: assert property (CHAN_VALID_O && CHAN_OUT_O.gain_code == 5'h1f |->
        CHAN_OUT_O.mute && CHAN_OUT_O.data == 8'hff) else $error("muted channel not silent");
    chk_gain_pass: assert property (CHAN_VALID_O && CHAN_OUT_O.gain_code != 5'h1f |->
        !CHAN_OUT_O.mute) else $error("unmuted code muted");
    chk_fetch_data: assert property (DM_RD_O |-> dm_fetch) else $error("fetched byte lost");
    chk_fetch_tick: assert property (DM_RD_O |->
        $past(SLOT_TICK_I, 2) && !$past(FRAME_START_I, 2)) else $error("fetch without tick");
    chk_msg_nofetch: assert property (CHAN_VALID_O && CHAN_OUT_O.src_class == tsi_pkg::SRC_MESSAGE |->
        !$past(DM_RD_O)) else $error("message slot fetched memory");
    chk_drive_off: assert property (CHAN_VALID_O && !OUTPUT_DRIVE_ENABLE_PIN_I &&
        !$past(OUTPUT_DRIVE_ENABLE_PIN_I, 2) |-> !CHAN_OUT_O.drive) else $error("drive with pin low");
    chk_drive_forced: assert property (CHAN_VALID_O && OUTPUT_DRIVE_ENABLE_PIN_I && CTL_BIT5_I &&
        $past(OUTPUT_DRIVE_ENABLE_PIN_I && CTL_BIT5_I, 2) |-> CHAN_OUT_O.drive) else $error("drive not forced");
    chk_exp_block: assert property (CHAN_VALID_O && CHAN_OUT_O.src_class == tsi_pkg::SRC_EXPANSION |->
        CHAN_OUT_O.src_block[2]) else $error("expansion class on low block");
    chk_local_block: assert property (CHAN_VALID_O && CHAN_OUT_O.src_class == tsi_pkg::SRC_LOCAL |->
        CHAN_OUT_O.src_block[2:1] == 2'b00) else $error("local class on wrong block");
    chk_party_slot: assert property (PARTY_VALID_O |->
        $past(SLOT_TICK_I, 3) && PARTY_OUT_O.party <= 4'he) else $error("bad party pulse");
endmodule : tsi_decode_checker

bind tsi_connection_word_decode tsi_decode_checker i_chk (.CLOCK_I(CLOCK_I), .RESET_I(RESET_I),
    .FRAME_START_I(FRAME_START_I), .SLOT_TICK_I(SLOT_TICK_I), .CTL_BIT5_I(CTL_BIT5_I),
    .OUTPUT_DRIVE_ENABLE_PIN_I(OUTPUT_DRIVE_ENABLE_PIN_I), .DM_RD_O(DM_RD_O), .DM_DATA_I(DM_DATA_I),
    .CHAN_OUT_O(CHAN_OUT_O), .CHAN_VALID_O(CHAN_VALID_O), .PARTY_OUT_O(PARTY_OUT_O), .PARTY_VALID_O(PARTY_VALID_O));
